// file: hw/sste_defs.vh
/*
 * Constants for the shift/subtract/test execution block: opcodes, flag
 * positions, register offsets and the AHB-Lite register map.
 * Assumes an AHB-Lite master with single word transfers only.
 */
`ifndef SSTE_DEFS_VH
`define SSTE_DEFS_VH

`define SSTE_OP_NONE 3'h0
`define SSTE_OP_ASR 3'h1
`define SSTE_OP_PTR 3'h2
`define SSTE_OP_STOP 3'h3
`define SSTE_OP_SUB 3'h4
`define SSTE_OP_SWAP 3'h5
`define SSTE_OP_TCM 3'h6

`define SSTE_FL_C 7
`define SSTE_FL_Z 6
`define SSTE_FL_S 5
`define SSTE_FL_V 4
`define SSTE_FL_D 3
`define SSTE_FL_H 2

`define SSTE_SEL_LOW 2'h2
`define SSTE_SEL_HIGH 2'h1
`define SSTE_SEL_BOTH 2'h0

`define SSTE_PTR_LOW_FILE 8'hD6
`define SSTE_PTR_HIGH_FILE 8'hD7

`define SSTE_ADDR_CTRL 10'h000
`define SSTE_ADDR_STAT 10'h004
`define SSTE_ADDR_DST 10'h008
`define SSTE_ADDR_SRC 10'h00C
`define SSTE_ADDR_FLAGS 10'h010
`define SSTE_ADDR_RESULT 10'h014
// Pointer indices; their bus byte address is four times the index
`define SSTE_ADDR_PTR_LOW 8'hD6
`define SSTE_ADDR_PTR_HIGH 8'hD7
`define SSTE_ADDR_PTR_LOW_W 10'h358
`define SSTE_ADDR_PTR_HIGH_W 10'h35C

`define SSTE_HTRANS_NONSEQ 2'h2
`define SSTE_CTRL_GO 3
`define SSTE_CTRL_WAKE 4
`define SSTE_ZERO8 8'h00
`define SSTE_ZERO10 10'h000
`define SSTE_ZERO32 32'h00000000

`endif

// file: hw/sste_alu.v
/*
 * Combinational result and flag logic for the four operations ASR, SUB, SWAP and TCM.
 * Assumes operands are stable while op is presented.
 */
`include "sste_defs.vh"

module sste_alu (
    input wire [2:0] op,
    input wire [7:0] dst,
    input wire [7:0] src,
    input wire [7:0] flags_in,
    output reg [7:0] result,
    output reg [7:0] flags_out,
    output reg write_dst
);
    reg [8:0] diff;
    reg [4:0] low_diff;

    always @* begin
        diff = {1'b0, dst} - {1'b0, src};
        low_diff = {1'b0, dst[3:0]} - {1'b0, src[3:0]};
        result = dst;
        flags_out = flags_in;
        write_dst = 1'b0;
        case (op)
            `SSTE_OP_ASR: begin
                result = {dst[7], dst[7:1]};
                write_dst = 1'b1;
                flags_out[`SSTE_FL_C] = dst[0];
                flags_out[`SSTE_FL_Z] = ({dst[7], dst[7:1]} == `SSTE_ZERO8);
                flags_out[`SSTE_FL_S] = dst[7];
                flags_out[`SSTE_FL_V] = 1'b0;
            end
            `SSTE_OP_SUB: begin
                result = diff[7:0];
                write_dst = 1'b1;
                flags_out[`SSTE_FL_C] = diff[8];
                flags_out[`SSTE_FL_Z] = (diff[7:0] == `SSTE_ZERO8);
                flags_out[`SSTE_FL_S] = diff[7];
                flags_out[`SSTE_FL_V] = (dst[7] ^ src[7]) & (diff[7] == src[7]);
                flags_out[`SSTE_FL_D] = 1'b1;
                flags_out[`SSTE_FL_H] = low_diff[4];
            end
            `SSTE_OP_SWAP: begin
                result = {dst[3:0], dst[7:4]};
                write_dst = 1'b1;
            end
            `SSTE_OP_TCM: begin
                result = ~dst & src;
                flags_out[`SSTE_FL_Z] = ((~dst & src) == `SSTE_ZERO8);
                flags_out[`SSTE_FL_S] = ~dst[7] & src[7];
                flags_out[`SSTE_FL_V] = 1'b0;
            end
            default: begin
                result = dst;
            end
        endcase
    end
endmodule

// file: hw/sste_exec.v
/*
 * Execution unit: AHB-Lite register file, operation launch, pointer load
 * and stop-mode control. Assumes a single AHB-Lite master, word transfers.
 */
`include "sste_defs.vh"

module sste_exec (
    input wire clk,
    input wire rst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire ext_irq,
    output reg stop_mode,
    output wire cpu_clk_en,
    output wire sys_clk_en
);
    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg [7:0] dst_reg;
    reg [7:0] src_reg;
    reg [7:0] flags;
    reg [7:0] result_reg;
    reg [7:0] working_reg_pointer_low;
    reg [7:0] working_reg_pointer_high;
    reg [2:0] last_op;
    reg done;
    reg wr_pend;
    reg [9:0] wr_addr;
    reg [7:0] next_ptr_low;
    reg [7:0] next_ptr_high;
    wire [7:0] alu_result;
    wire [7:0] alu_flags;
    wire alu_write;
    wire go;
    wire [2:0] go_op;
    wire wake;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign cpu_clk_en = ~stop_mode;
    assign sys_clk_en = ~stop_mode;
    assign go = wr_pend & (wr_addr == `SSTE_ADDR_CTRL) & hwdata[`SSTE_CTRL_GO];
    assign go_op = hwdata[2:0];
    assign wake = ext_irq |
        (wr_pend & (wr_addr == `SSTE_ADDR_CTRL) & hwdata[`SSTE_CTRL_WAKE]);

    sste_alu sste_alu_i (
        .op(go_op),
        .dst(dst_reg),
        .src(src_reg),
        .flags_in(flags),
        .result(alu_result),
        .flags_out(alu_flags),
        .write_dst(alu_write)
    );

    // ----------------------------------------
    // Pointer load selection
    // ----------------------------------------
    always @* begin
        next_ptr_low = working_reg_pointer_low;
        next_ptr_high = working_reg_pointer_high;
        case (src_reg[1:0])
            `SSTE_SEL_LOW: begin
                next_ptr_low = {src_reg[7:3], working_reg_pointer_low[2:0]};
            end
            `SSTE_SEL_HIGH: begin
                next_ptr_high = {src_reg[7:3], working_reg_pointer_high[2:0]};
            end
            `SSTE_SEL_BOTH: begin
                next_ptr_low = {src_reg[7:4], 1'b0, working_reg_pointer_low[2:0]};
                next_ptr_high = {src_reg[7:4], 1'b1, working_reg_pointer_high[2:0]};
            end
            default: begin
                next_ptr_low = working_reg_pointer_low;
            end
        endcase
    end

    // ----------------------------------------
    // Bus write capture and execution
    // ----------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            wr_addr <= `SSTE_ZERO10;
            dst_reg <= `SSTE_ZERO8;
            src_reg <= `SSTE_ZERO8;
            flags <= `SSTE_ZERO8;
            result_reg <= `SSTE_ZERO8;
            working_reg_pointer_low <= `SSTE_ZERO8;
            working_reg_pointer_high <= `SSTE_ZERO8;
            last_op <= `SSTE_OP_NONE;
            done <= 1'b0;
            stop_mode <= 1'b0;
        end else begin
            wr_pend <= hsel & hready & hwrite & htrans[1];
            wr_addr <= haddr[9:0];
            if (stop_mode) begin
                if (wake) begin
                    stop_mode <= 1'b0;
                end
            end else if (go) begin
                // Results commit in one edge
                last_op <= go_op;
                done <= 1'b1;
                result_reg <= alu_result;
                flags <= alu_flags;
                if (alu_write) begin
                    dst_reg <= alu_result;
                end
                if (go_op == `SSTE_OP_PTR) begin
                    working_reg_pointer_low <= next_ptr_low;
                    working_reg_pointer_high <= next_ptr_high;
                end
                if (go_op == `SSTE_OP_STOP) begin
                    stop_mode <= 1'b1;
                end
            end else if (wr_pend) begin
                case (wr_addr)
                    `SSTE_ADDR_DST: dst_reg <= hwdata[7:0];
                    `SSTE_ADDR_SRC: src_reg <= hwdata[7:0];
                    `SSTE_ADDR_FLAGS: flags <= hwdata[7:0];
                    `SSTE_ADDR_PTR_LOW_W: working_reg_pointer_low <= hwdata[7:0];
                    `SSTE_ADDR_PTR_HIGH_W: working_reg_pointer_high <= hwdata[7:0];
                    default: done <= done;
                endcase
            end
            // Stop mode freezes every register but stop_mode, wr_pend, wr_addr, rd_pend and rd_addr
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    reg rd_pend;
    reg [9:0] rd_addr;
    always @(posedge clk) begin
        if (!rst_n) begin
            rd_pend <= 1'b0;
            rd_addr <= `SSTE_ZERO10;
        end else begin
            rd_pend <= hsel & hready & ~hwrite & htrans[1];
            rd_addr <= haddr[9:0];
        end
    end

    always @* begin
        hrdata = `SSTE_ZERO32;
        if (rd_pend) begin
            case (rd_addr)
                `SSTE_ADDR_CTRL: hrdata = {29'h0, last_op};
                `SSTE_ADDR_STAT: hrdata = {30'h0, done, stop_mode};
                `SSTE_ADDR_DST: hrdata = {24'h0, dst_reg};
                `SSTE_ADDR_SRC: hrdata = {24'h0, src_reg};
                `SSTE_ADDR_FLAGS: hrdata = {24'h0, flags};
                `SSTE_ADDR_RESULT: hrdata = {24'h0, result_reg};
                `SSTE_ADDR_PTR_LOW_W: hrdata = {24'h0, working_reg_pointer_low};
                `SSTE_ADDR_PTR_HIGH_W: hrdata = {24'h0, working_reg_pointer_high};
                default: hrdata = `SSTE_ZERO32;
            endcase
        end
    end
endmodule

// file: sim/sste_exec_props.sv
/* Port checker for sste_exec: bus answer, clock gating, stop entry and exit.
   Assumes one clock domain and the one bus master of the bench. */
module sste_exec_chk (
    input wire clk,
    input wire rst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire ext_irq,
    input wire stop_mode,
    input wire cpu_clk_en,
    input wire sys_clk_en
);
timeunit 1ns;
timeprecision 1ps;
reg aw;
reg ar;
reg [9:0] aa;
wire go = aw && aa == 10'h000;
// Address phase seen last cycle
always @(posedge clk) begin
    aw <= rst_n && hsel && hready && htrans == 2'h2 && hwrite;
    ar <= rst_n && hsel && hready && htrans == 2'h2 && !hwrite;
    aa <= haddr[9:0];
end
default clocking @(posedge clk);
endclocking
default disable iff (!rst_n);
ready_always_a: assert property (hreadyout && !hresp) else $error("bus answer late");
rdata_width_a: assert property (hrdata[31:8] == 24'h000000) else $error("wide read data");
clk_gate_a: assert property (cpu_clk_en == !stop_mode && sys_clk_en == !stop_mode)
    else $error("clock enables wrong");
stop_enter_a: assert property (!stop_mode && !ext_irq && go && hwdata[3] && hwdata[2:0] == 3'h3
    |=> stop_mode) else $error("no stop entry");
stop_hold_a: assert property (stop_mode && !ext_irq && !(go && hwdata[4]) |=> stop_mode)
    else $error("stop left early");
irq_exit_a: assert property (stop_mode && ext_irq |=> !stop_mode) else $error("irq no exit");
wake_exit_a: assert property (stop_mode && go && hwdata[4] |=> !stop_mode) else $error("no wake");
reset_exit_a: assert property (disable iff (1'b0) !rst_n |=> !stop_mode)
    else $error("reset no exit");
cover property ($rose(stop_mode));
cover property (stop_mode && ext_irq);
cover property (ar);
endmodule
bind sste_exec sste_exec_chk sste_exec_chk_i (.*);

// file: sim/sste_wake.sv
/* External wake source: drives the interrupt input of sste_exec.
   Assumes the bench raises fire just after a rising edge. */
module sste_wake (
    input wire clk,
    input wire fire,
    output logic ext_irq
);
timeunit 1ns;
timeprecision 1ps;
initial ext_irq = 1'b0;
always @(posedge clk) begin
    ext_irq <= fire;
end
endmodule

// file: sim/sste_exec_tb.sv
/* Self-checking bench for sste_exec: op table, pointer loads, stop mode.
   Assumes the register map and zero-wait answer of the design. */
`include "sste_defs.vh"
module sste_exec_tb;
timeunit 1ns;
timeprecision 1ps;
typedef struct packed {logic [2:0] op; logic [7:0] d, s, f, r, fo, m;} sste_row_t;
logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, fire = 1'b0;
logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000, rd;
logic [1:0] htrans = 2'h0;
logic [2:0] hsize = 3'h2;
wire [31:0] hrdata;
wire hreadyout, hresp, ext_irq, stop_mode, cpu_clk_en, sys_clk_en;
wire hready = hreadyout;
int bad_count = 0, samples_checked = 0;
sste_row_t rows [8] = '{
    '{3'h1, 8'h9A, 8'h00, 8'h9C, 8'hCD, 8'h2C, 8'hFC}, '{3'h1, 8'h01, 8'h00, 8'h00, 8'h00, 8'hC0, 8'hFC},
    '{3'h4, 8'h12, 8'h03, 8'h00, 8'h0F, 8'h0C, 8'hFC}, '{3'h4, 8'h21, 8'h90, 8'h00, 8'h91, 8'hB8, 8'hFC},
    '{3'h4, 8'h05, 8'h05, 8'hFC, 8'h00, 8'h48, 8'hFC}, '{3'h5, 8'h3C, 8'h00, 8'hA4, 8'hC3, 8'hA4, 8'h00},
    '{3'h6, 8'hC7, 8'h02, 8'h9C, 8'hC7, 8'hCC, 8'hFC}, '{3'h6, 8'h2B, 8'h80, 8'h50, 8'h2B, 8'h20, 8'hFC}};
logic [23:0] pt [4] = '{24'h5257FF, 24'h69576F, 24'h03576F, 24'h40474F};
sste_exec sste_exec_i (
    .clk(clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .ext_irq(ext_irq),
    .stop_mode(stop_mode),
    .cpu_clk_en(cpu_clk_en),
    .sys_clk_en(sys_clk_en)
);
sste_wake sste_wake_i (.clk(clk), .fire(fire), .ext_irq(ext_irq));
always #4 clk = ~clk;
// ----------------------------------------
// Checking and bus tasks
// ----------------------------------------
task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
        bad_count++;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
endtask
task edge1;
    int n;
    n = 0;
    do begin
        @(posedge clk);
        rd = hrdata;
        n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
        bad_count++;
        complete_run;
    end
endtask
task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h000000, a};
    hwrite <= w;
    edge1;
    htrans <= 2'h0;
    hwdata <= d;
    edge1;
endtask
task rchk(input logic [9:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(rd, {24'h000000, e});
endtask
task wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h000000, d});
endtask
initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
        wr(`SSTE_ADDR_FLAGS, rows[i].f);
        wr(`SSTE_ADDR_DST, rows[i].d);
        wr(`SSTE_ADDR_SRC, rows[i].s);
        wr(`SSTE_ADDR_CTRL, {5'h01, rows[i].op});
        rchk(`SSTE_ADDR_DST, rows[i].r);
        rchk(`SSTE_ADDR_SRC, rows[i].s);
        bus(1'b0, `SSTE_ADDR_FLAGS, 32'h00000000);
        chk(rd & {24'h000000, rows[i].m}, {24'h000000, rows[i].fo & rows[i].m});
    end
    rchk(`SSTE_ADDR_RESULT, 8'h80);
    wr(`SSTE_ADDR_PTR_LOW_W, 8'hFF);
    wr(`SSTE_ADDR_PTR_HIGH_W, 8'hFF);
    wr(`SSTE_ADDR_FLAGS, 8'hA8);
    foreach (pt[i]) begin
        wr(`SSTE_ADDR_SRC, pt[i][23:16]);
        wr(`SSTE_ADDR_CTRL, 8'h0A);
        rchk(`SSTE_ADDR_PTR_LOW_W, pt[i][15:8]);
        rchk(`SSTE_ADDR_PTR_HIGH_W, pt[i][7:0]);
    end
    rchk(`SSTE_ADDR_FLAGS, 8'hA8);
    wr(`SSTE_ADDR_DST, 8'hA5);
    wr(`SSTE_ADDR_CTRL, 8'h0B);
    // Three idle slots after the stop request
    repeat (3) @(posedge clk);
    chk({30'h00000000, cpu_clk_en | sys_clk_en, stop_mode}, 32'h00000001);
    rchk(`SSTE_ADDR_STAT, 8'h03);
    rchk(`SSTE_ADDR_CTRL, 8'h03);
    wr(`SSTE_ADDR_DST, 8'h11);
    rchk(`SSTE_ADDR_DST, 8'hA5);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h00000000, stop_mode}, 32'h00000000);
    wr(`SSTE_ADDR_CTRL, 8'h0B);
    wr(`SSTE_ADDR_CTRL, 8'h10);
    @(posedge clk);
    chk({31'h00000000, stop_mode}, 32'h00000000);
    wr(`SSTE_ADDR_CTRL, 8'h0B);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({31'h00000000, stop_mode}, 32'h00000000);
    rchk(`SSTE_ADDR_DST, 8'h00);
    rchk(10'h020, 8'h00);
    complete_run;
end
endmodule
